// ---- asc_seq.sv ----
// Acquisition sequencer: init, stabilisation, sampling, standby, registers.
`timescale 1ns/1ps
module asc_seq #(
  parameter int unsigned INIT_CYC = asc_pkg::INIT_CYC,
  parameter int unsigned STAB_CYC = asc_pkg::STAB_CYC,
  parameter int unsigned SETTLE_CYC = asc_pkg::SETTLE_CYC,
  parameter int unsigned STANDBY_CYC = asc_pkg::STANDBY_CYC,
  parameter int unsigned SLOW_HALF_CYC = asc_pkg::SLOW_HALF_CYC,
  parameter int unsigned CLK_HZ = asc_pkg::CLK_HZ
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Serial pins.
  input wire logic sclk,
  input wire logic csn,
  input wire logic mosi,
  output logic miso,
  // Interrupt pin.
  output logic int_pin,
  // Conversion results from the analog datapath.
  input wire logic [15:0] conv_i,
  input wire logic [15:0] conv_v,
  // Datapath controls.
  output logic [7:0] gain_out,
  output logic [7:0] achan_out,
  output logic slow_osc,
  output logic init_busy
);

  logic [1:0] sclk_q_r;
  logic [1:0] csn_q_r;
  logic [1:0] mosi_q_r;
  asc_pkg::asc_req_t req;
  logic [7:0] rdata;
  logic spi_miso;
  asc_pkg::asc_state_t state_r;
  logic [7:0] gain_r;
  logic [7:0] achan_r;
  logic [7:0] mode_r;
  logic [7:0] clocks_r;
  logic [7:0] reset_r;
  logic [7:0] status_r;
  logic [15:0] data_i_r;
  logic [15:0] data_v_r;
  logic gain_bad_r;
  logic [1:0] sbm_cnt_r;
  logic soft_rst_r;
  logic t_load;
  logic [31:0] t_count;
  logic t_busy;
  logic t_done;
  logic t_stop;
  logic [31:0] sample_cyc;
  logic [31:0] window_cyc;
  logic [31:0] phase_r;
  logic [31:0] settle_r;
  logic sample_tick;
  logic running;
  logic [15:0] slow_cnt_r;
  logic int_r;

  // Two-stage synchronisers for every serial input pin.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sclk_q_r <= 2'b00;
      csn_q_r <= 2'b11;
      mosi_q_r <= 2'b00;
    end else begin
      sclk_q_r <= {sclk_q_r[0], sclk};
      csn_q_r <= {csn_q_r[0], csn};
      mosi_q_r <= {mosi_q_r[0], mosi};
    end
  end

  asc_spi_slave u_spi (
    .mclk(mclk),
    .rstn(rstn),
    .sclk_s(sclk_q_r[1]),
    .csn_s(csn_q_r[1]),
    .mosi_s(mosi_q_r[1]),
    .rdata(rdata),
    .req(req),
    .miso(spi_miso)
  );

  // Sample period R2/(2*chop): chop 2 kHz or 4 kHz in cycles.
  always_comb begin
    sample_cyc = 32'(CLK_HZ / 4000);
    if (clocks_r[asc_pkg::CLK_CHOP4_BIT]) begin
      sample_cyc = 32'(CLK_HZ / 8000);
    end
    sample_cyc = sample_cyc * 32'(asc_pkg::R2_DEFAULT);
  end

  // Read window: R1/mod * (mod/(2*chop*R1) - 2.5), in cycles.
  always_comb begin
    logic [31:0] mod_hz;
    logic [31:0] chop_hz;
    logic [31:0] r1;
    mod_hz = clocks_r[asc_pkg::CLK_MOD2_BIT] ? 32'd2_000_000 : 32'd1_000_000;
    chop_hz = clocks_r[asc_pkg::CLK_CHOP4_BIT] ? 32'd4000 : 32'd2000;
    r1 = clocks_r[asc_pkg::CLK_R1_128_BIT] ? 32'd128 : 32'd64;
    // Twice the window in module-clock periods avoids the half fraction.
    window_cyc = ((32'(CLK_HZ) / (chop_hz)) -
                  (32'd5 * r1 * (32'(CLK_HZ) / mod_hz))) >> 1;
  end

  assign running = (state_r == asc_pkg::ASC_RUN);
  assign sample_tick = running && (phase_r + 32'd1 >= sample_cyc);

  // Phase inside the sample period and the settling age.
  // The phase keeps counting in standby so the read window still closes.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phase_r <= '0;
      settle_r <= '0;
    end else if (!running && state_r != asc_pkg::ASC_SB_WAIT) begin
      phase_r <= '0;
      settle_r <= '0;
    end else begin
      phase_r <= sample_tick ? 32'd0 : phase_r + 32'd1;
      if (!running) begin
        settle_r <= '0;
      end else if (settle_r < SETTLE_CYC) begin
        settle_r <= settle_r + 32'd1;
      end
    end
  end

  // Timer loads for init, stabilisation and standby.
  always_comb begin
    t_load = 1'b0;
    t_count = 32'(INIT_CYC);
    if (soft_rst_r) begin
      t_load = 1'b1;
    end else if (!t_busy && !t_done) begin
      if (state_r == asc_pkg::ASC_INIT) begin
        t_load = 1'b1;
      end else if (state_r == asc_pkg::ASC_STAB) begin
        t_load = 1'b1;
        t_count = 32'(STAB_CYC);
      end else if (state_r == asc_pkg::ASC_SB_WAIT) begin
        t_load = 1'b1;
        t_count = 32'(STANDBY_CYC);
      end
    end
  end

  // Stop drops a pending standby count so it cannot end a later wait.
  assign t_stop = (state_r == asc_pkg::ASC_STOP);

  asc_timer #(.W(32)) u_tmr (
    .mclk(mclk),
    .rstn(rstn),
    .load(t_load),
    .count(t_count),
    .stop(t_stop),
    .busy(t_busy),
    .done(t_done)
  );

  // Main state walk.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= asc_pkg::ASC_INIT;
    end else if (soft_rst_r) begin
      state_r <= asc_pkg::ASC_INIT;
    end else begin
      unique case (state_r)
        asc_pkg::ASC_INIT: begin
          if (t_done) begin
            state_r <= asc_pkg::ASC_STOP;
          end
        end
        asc_pkg::ASC_STOP: begin
          if (!mode_r[asc_pkg::MODE_STOP_BIT]) begin
            state_r <= asc_pkg::ASC_STAB;
          end
        end
        asc_pkg::ASC_STAB: begin
          if (t_done) begin
            state_r <= asc_pkg::ASC_RUN;
          end
        end
        asc_pkg::ASC_RUN: begin
          if (mode_r[asc_pkg::MODE_STOP_BIT]) begin
            state_r <= asc_pkg::ASC_STOP;
          end else if (sample_tick && mode_r[asc_pkg::MODE_SBM_BIT] &&
                       settle_r >= SETTLE_CYC &&
                       sbm_cnt_r == 2'(asc_pkg::SBM_SKIP - 1)) begin
            state_r <= asc_pkg::ASC_SB_WAIT;
          end
        end
        asc_pkg::ASC_SB_WAIT: begin
          if (!mode_r[asc_pkg::MODE_SBM_BIT] ||
              mode_r[asc_pkg::MODE_STOP_BIT]) begin
            state_r <= asc_pkg::ASC_STOP;
          end else if (t_done) begin
            state_r <= asc_pkg::ASC_STAB;
          end
        end
      endcase
    end
  end

  // Standby counts conversions and forwards every third one.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sbm_cnt_r <= 2'b00;
    end else if (!running) begin
      sbm_cnt_r <= 2'b00;
    end else if (sample_tick && settle_r >= SETTLE_CYC &&
                 mode_r[asc_pkg::MODE_SBM_BIT]) begin
      if (sbm_cnt_r == 2'(asc_pkg::SBM_SKIP - 1)) begin
        sbm_cnt_r <= 2'b00;
      end else begin
        sbm_cnt_r <= sbm_cnt_r + 2'b01;
      end
    end
  end

  // Writable registers; none accept during init, and outside stop and init all but the clocks register accept.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gain_r <= asc_pkg::ZERO8;
      achan_r <= asc_pkg::ZERO8;
      mode_r <= asc_pkg::MODE_RST;
      clocks_r <= asc_pkg::ZERO8;
      reset_r <= asc_pkg::RESET_RST;
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= 1'b0;
      reset_r[asc_pkg::RST_BIT] <= 1'b1;
      if (req.wr && !init_busy) begin
        unique case (req.addr)
          asc_pkg::ADDR_GAIN: gain_r <= req.wdata;
          asc_pkg::ADDR_ACHAN: achan_r <= req.wdata;
          asc_pkg::ADDR_MODE: mode_r <= req.wdata;
          asc_pkg::ADDR_CLOCKS: begin
            if (state_r == asc_pkg::ASC_STOP) begin
              clocks_r <= req.wdata;
            end
          end
          asc_pkg::ADDR_RESET: begin
            if (!req.wdata[asc_pkg::RST_BIT]) begin
              soft_rst_r <= 1'b1;
              mode_r <= asc_pkg::MODE_RST;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Gain change while running marks the next sample invalid.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gain_bad_r <= 1'b0;
    end else if (req.wr && req.addr == asc_pkg::ADDR_GAIN && running) begin
      gain_bad_r <= 1'b1;
    end else if (sample_tick) begin
      gain_bad_r <= 1'b0;
    end
  end

  // Data registers and status; set wins over the read clear.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      data_i_r <= '0;
      data_v_r <= '0;
      status_r <= asc_pkg::ZERO8;
    end else begin
      if (req.rd && req.addr == asc_pkg::ADDR_STATUS) begin
        status_r <= asc_pkg::ZERO8;
      end
      if (sample_tick && settle_r >= SETTLE_CYC &&
          (!mode_r[asc_pkg::MODE_SBM_BIT] ||
           sbm_cnt_r == 2'(asc_pkg::SBM_SKIP - 1))) begin
        data_i_r <= conv_i;
        data_v_r <= conv_v;
        status_r[asc_pkg::STAT_RDY_BIT] <= 1'b1;
        status_r[asc_pkg::STAT_GINV_BIT] <= gain_bad_r;
      end
    end
  end

  // Read multiplexer.
  always_comb begin
    unique case (req.addr)
      asc_pkg::ADDR_GAIN: rdata = gain_r;
      asc_pkg::ADDR_ACHAN: rdata = achan_r;
      asc_pkg::ADDR_MODE: rdata = mode_r;
      asc_pkg::ADDR_CLOCKS: rdata = clocks_r;
      asc_pkg::ADDR_RESET: rdata = reset_r;
      asc_pkg::ADDR_STATUS: rdata = status_r;
      asc_pkg::ADDR_DATA_I_HI: rdata = data_i_r[15:8];
      asc_pkg::ADDR_DATA_I_LO: rdata = data_i_r[7:0];
      asc_pkg::ADDR_DATA_V_HI: rdata = data_v_r[15:8];
      asc_pkg::ADDR_DATA_V_LO: rdata = data_v_r[7:0];
      default: rdata = asc_pkg::ZERO8;
    endcase
  end

  // Slow oscillator toggle used on the interrupt pin during init.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      slow_cnt_r <= '0;
      int_r <= 1'b0;
    end else if (state_r == asc_pkg::ASC_INIT) begin
      if (slow_cnt_r + 16'd1 >= 16'(SLOW_HALF_CYC)) begin
        slow_cnt_r <= '0;
        int_r <= ~int_r;
      end else begin
        slow_cnt_r <= slow_cnt_r + 16'd1;
      end
    end else if (sample_tick && settle_r >= SETTLE_CYC &&
                 (!mode_r[asc_pkg::MODE_SBM_BIT] ||
                  sbm_cnt_r == 2'(asc_pkg::SBM_SKIP - 1))) begin
      int_r <= 1'b1;
    end else if (phase_r == window_cyc ||
                 (!running && state_r != asc_pkg::ASC_SB_WAIT)) begin
      int_r <= 1'b0;
    end
  end

  // Registered outputs.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      int_pin <= 1'b0;
      miso <= 1'b0;
      gain_out <= asc_pkg::ZERO8;
      achan_out <= asc_pkg::ZERO8;
      slow_osc <= 1'b0;
      init_busy <= 1'b1;
    end else begin
      int_pin <= int_r;
      miso <= spi_miso;
      gain_out <= gain_r;
      achan_out <= achan_r;
      slow_osc <= (state_r == asc_pkg::ASC_SB_WAIT);
      init_busy <= (state_r == asc_pkg::ASC_INIT);
    end
  end

endmodule

// ---- asc_pkg.sv ----
// Package with constants and types for the sequencer.
package asc_pkg;

  // Clock rate and timing figures in their own units.
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned INIT_US = 500;
  localparam int unsigned STAB_US = 1500;
  localparam int unsigned SETTLE_US = 2000;
  localparam int unsigned INVALID_US = 8;
  localparam int unsigned STANDBY_S = 10;
  localparam int unsigned SLOW_OSC_HZ = 262_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned INIT_CYC = INIT_US * CYC_PER_US;
  localparam int unsigned STAB_CYC = STAB_US * CYC_PER_US;
  localparam int unsigned SETTLE_CYC = SETTLE_US * CYC_PER_US;
  localparam int unsigned INVALID_CYC = INVALID_US * CYC_PER_US;
  localparam int unsigned STANDBY_CYC = STANDBY_S * CLK_HZ;
  // Half period of the slow oscillator, rounded down.
  localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_OSC_HZ);
  // Standby forwards every third conversion.
  localparam int unsigned SBM_SKIP = 3;

  // Register addresses.
  localparam logic [7:0] ADDR_GAIN = 8'h03;
  localparam logic [7:0] ADDR_MODE = 8'h05;
  localparam logic [7:0] ADDR_STATUS = 8'h07;
  localparam logic [7:0] ADDR_RESET = 8'h09;
  localparam logic [7:0] ADDR_CLOCKS = 8'h0b;
  localparam logic [7:0] ADDR_ACHAN = 8'h17;
  localparam logic [7:0] ADDR_DATA_I_HI = 8'h1a;
  localparam logic [7:0] ADDR_DATA_I_LO = 8'h1b;
  localparam logic [7:0] ADDR_DATA_V_HI = 8'h1c;
  localparam logic [7:0] ADDR_DATA_V_LO = 8'h1d;

  // Field positions and reset values.
  localparam int unsigned RST_BIT = 7;
  localparam int unsigned MODE_STOP_BIT = 0;
  localparam int unsigned MODE_SBM_BIT = 1;
  localparam int unsigned STAT_RDY_BIT = 0;
  localparam int unsigned STAT_GINV_BIT = 1;
  localparam int unsigned CLK_MOD2_BIT = 0;
  localparam int unsigned CLK_CHOP4_BIT = 1;
  localparam int unsigned CLK_R1_128_BIT = 2;
  localparam logic [7:0] RESET_RST = 8'h80;
  localparam logic [7:0] MODE_RST = 8'h01;
  localparam logic [7:0] ZERO8 = 8'h00;
  localparam logic [7:0] R2_DEFAULT = 8'h04;

  // Serial command frame: first byte bit 7 set means read.
  localparam int unsigned CMD_RD_BIT = 7;

  // Operating states.
  typedef enum logic [2:0] {
    ASC_INIT, ASC_STOP, ASC_STAB, ASC_RUN, ASC_SB_WAIT
  } asc_state_t;

  // Register access request from the serial slave.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } asc_req_t;

endpackage

// ---- asc_spi_slave.sv ----
// Four-wire serial slave that turns frames into register accesses.
`timescale 1ns/1ps
module asc_spi_slave (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Synchronised serial pins.
  input wire logic sclk_s,
  input wire logic csn_s,
  input wire logic mosi_s,
  // Register side.
  input wire logic [7:0] rdata,
  output asc_pkg::asc_req_t req,
  output logic miso
);

  logic sclk_d_r;
  logic [3:0] bit_cnt_r;
  logic byte_idx_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic [7:0] addr_r;
  logic rd_r;
  logic rise;
  logic fall;

  assign rise = sclk_s & ~sclk_d_r & ~csn_s;
  assign fall = ~sclk_s & sclk_d_r & ~csn_s;

  // Edge history of the serial clock.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= sclk_s;
    end
  end

  // Shift in bits, decode address byte then data byte.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_r <= 4'h0;
      byte_idx_r <= 1'b0;
      sh_r <= 8'h00;
      addr_r <= 8'h00;
      rd_r <= 1'b0;
      req <= '0;
    end else begin
      req.wr <= 1'b0;
      req.rd <= 1'b0;
      if (csn_s) begin
        bit_cnt_r <= 4'h0;
        byte_idx_r <= 1'b0;
      end else if (rise) begin
        sh_r <= {sh_r[6:0], mosi_s};
        if (bit_cnt_r == 4'h7) begin
          bit_cnt_r <= 4'h0;
          if (!byte_idx_r) begin
            byte_idx_r <= 1'b1;
            rd_r <= sh_r[6];
            addr_r <= {1'b0, sh_r[5:0], mosi_s};
            req.addr <= {1'b0, sh_r[5:0], mosi_s};
            req.rd <= sh_r[6];
          end else begin
            req.wr <= ~rd_r;
            req.addr <= addr_r;
            req.wdata <= {sh_r[6:0], mosi_s};
          end
        end else begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
      end
    end
  end

  // Read data leaves most significant bit first on falling edges.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_r <= 8'h00;
      miso <= 1'b0;
    end else if (req.rd) begin
      tx_r <= rdata;
      miso <= 1'b0;
    end else if (fall && byte_idx_r && rd_r) begin
      miso <= tx_r[7];
      tx_r <= {tx_r[6:0], 1'b0};
    end
  end

endmodule

// ---- asc_timer.sv ----
// Loadable down counter that pulses when it runs out.
`timescale 1ns/1ps
module asc_timer #(
  parameter int unsigned W = 32
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Control.
  input wire logic load,
  input wire logic [W-1:0] count,
  input wire logic stop,
  // Status.
  output logic busy,
  output logic done
);

  logic [W-1:0] cnt_r;

  // Counts down from the loaded value; done marks the last cycle.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (stop) begin
        busy <= 1'b0;
      end else if (load) begin
        cnt_r <= count;
        busy <= 1'b1;
      end else if (busy) begin
        if (cnt_r <= W'(1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - W'(1);
        end
      end
    end
  end

endmodule

// ---- asc_seq_asserts.sv ----
// Checker of init, standby and data-ready timing at the sequencer pins.
`timescale 1ns/1ps
module asc_seq_asserts #(
  parameter int unsigned INIT_CYC = 200,
  parameter int unsigned STANDBY_CYC = 2000,
  parameter int unsigned SLOW_HALF_CYC = 381,
  parameter int unsigned CLK_HZ = 200_000_000
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rstn,
  // Watched outputs.
  input wire logic int_pin,
  input wire logic slow_osc,
  input wire logic init_busy
);
  // Read window bounds of 40 us and 180 us, with slack round the table.
  localparam int unsigned RDWIN_MIN = 40 * (CLK_HZ / 1_000_000);
  localparam int unsigned RDWIN_MAX = 180 * (CLK_HZ / 1_000_000);
  int unsigned cyc_r, init_r, tog_r, sb_r, hi_r;
  logic int_d_r;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  // Run lengths of init, a steady pin in init, standby and data ready.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cyc_r <= 0;
      init_r <= 0;
      tog_r <= 0;
      sb_r <= 0;
      hi_r <= 0;
      int_d_r <= 1'b0;
    end else begin
      cyc_r <= (cyc_r < 4) ? cyc_r + 1 : cyc_r;
      init_r <= init_busy ? init_r + 1 : 0;
      tog_r <= (init_busy && int_pin == int_d_r) ? tog_r + 1 : 0;
      sb_r <= slow_osc ? sb_r + 1 : 0;
      hi_r <= (int_pin && !init_busy) ? hi_r + 1 : 0;
      int_d_r <= int_pin;
    end
  end
  // Init starts at once, lasts its length and toggles the pin.
  property p_init_first; cyc_r == 1 |-> init_busy; endproperty
  a_init_first: assert property (p_init_first)
    else $error("init did not start after reset");
  property p_init_max; init_r <= INIT_CYC + 4; endproperty
  a_init_max: assert property (p_init_max)
    else $error("init lasted too long");
  property p_init_min; $fell(init_busy) |-> init_r >= INIT_CYC - 4;
  endproperty
  a_init_min: assert property (p_init_min)
    else $error("init ended too early");
  property p_init_tog; tog_r <= SLOW_HALF_CYC + 4; endproperty
  a_init_tog: assert property (p_init_tog)
    else $error("interrupt pin stopped toggling in init");
  property p_init_quiet; $fell(init_busy) |-> ##1 !int_pin [*8];
  endproperty
  a_init_quiet: assert property (p_init_quiet)
    else $error("interrupt right after init");
  // Standby timer and slow oscillator.
  property p_slow_max; sb_r <= STANDBY_CYC + 8; endproperty
  a_slow_max: assert property (p_slow_max)
    else $error("standby timer overran");
  property p_slow_init; init_busy |-> !slow_osc; endproperty
  a_slow_init: assert property (p_slow_init)
    else $error("slow oscillator during init");
  // Data ready stands for the read window.
  property p_int_max; hi_r <= RDWIN_MAX; endproperty
  a_int_max: assert property (p_int_max)
    else $error("data ready longer than read window");
  property p_int_min;
    $fell(int_pin) && !init_busy && !$past(init_busy, 2) |->
      hi_r >= RDWIN_MIN;
  endproperty
  a_int_min: assert property (p_int_min)
    else $error("data ready shorter than read window");
endmodule
bind asc_seq asc_seq_asserts #(.INIT_CYC(INIT_CYC),
  .STANDBY_CYC(STANDBY_CYC), .SLOW_HALF_CYC(SLOW_HALF_CYC),
  .CLK_HZ(CLK_HZ)) u_chk (
  .mclk(mclk), .rstn(rstn), .int_pin(int_pin), .slow_osc(slow_osc),
  .init_busy(init_busy));

// ---- asc_host_model.sv ----
// Host controller model driving serial register frames.
`timescale 1ns/1ps
module asc_host_model (
  // Clock.
  input wire logic mclk,
  // Serial pins.
  output logic sclk,
  output logic csn,
  output logic mosi,
  input wire logic miso
);
  // The link idles with its clock low and the select high.
  initial begin
    sclk = 1'b0;
    csn = 1'b1;
    mosi = 1'b0;
  end
  // Sends a 16-bit frame MSB first and captures the second byte.
  task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
    @(posedge mclk);
    csn <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi <= tx[i];
      repeat (8) @(posedge mclk);
      sclk <= 1'b1;
      if (i < 8) rx[i] = miso;
      repeat (8) @(posedge mclk);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge mclk);
    csn <= 1'b1;
    mosi <= ~mosi; // A released line does not keep its last value.
    repeat (8) @(posedge mclk);
  endtask
  // Register write and read.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] rx;
    xfer({2'b00, a[5:0], d}, rx);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] c;
    c = {2'b00, a[5:0]};
    c[asc_pkg::CMD_RD_BIT] = 1'b1;
    xfer({c, 8'h00}, d);
  endtask
endmodule

// ---- asc_seq_tb.sv ----
// Self-checking bench for the acquisition sequencer.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin @(negedge mclk); total_checks++; \
  if ((g) !== (e)) begin n_errors++; \
  $display("unexpected %s: expected %h seen %h", nm, e, g); end end
module asc_seq_tb;
  localparam int unsigned INIT = 1000;
  localparam int unsigned STAB = 300;
  localparam int unsigned SBY = 2000;
  // The clock rate is scaled to 8 MHz for sample and window timing.
  // Sample period at a 4 kHz chopper and second ratio 4 is 0.5 ms.
  localparam int unsigned SAMPLE_PERIOD = 4000;
  localparam int LIMIT = 80000;
  logic mclk, rstn, sclk, csn, mosi, miso, int_pin, slow_osc, init_busy;
  logic [15:0] conv_i, conv_v;
  logic [7:0] gain_out, achan_out, rv, ev;
  int n_errors, total_checks, cyc, n, t0;
  // Clock and time-zero inputs.
  initial mclk = 1'b0;
  always #2.5 mclk = ~mclk;
  asc_seq #(.INIT_CYC(INIT), .STAB_CYC(STAB), .SETTLE_CYC(400),
    .STANDBY_CYC(SBY), .CLK_HZ(8_000_000)) dut (.mclk(mclk), .rstn(rstn),
    .sclk(sclk),
    .csn(csn), .mosi(mosi), .miso(miso), .int_pin(int_pin),
    .conv_i(conv_i), .conv_v(conv_v), .gain_out(gain_out),
    .achan_out(achan_out), .slow_osc(slow_osc), .init_busy(init_busy));
  asc_host_model h (.mclk(mclk), .sclk(sclk), .csn(csn), .mosi(mosi),
    .miso(miso));
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Waits a bounded time for an output to reach a level.
  function automatic logic pick(input int s);
    return (s == 0) ? init_busy : (s == 1) ? slow_osc : int_pin;
  endfunction
  task automatic wait_lvl(input int s, input logic v, input int lim);
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(negedge mclk);
      n++;
    end
  endtask
  // Cuts a hang short.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_errors++;
      finish_test();
    end
  end
  // Main sequence.
  initial begin
    rstn = 1'b0;
    conv_i = 16'h1234;
    conv_v = 16'hbeef;
    cyc = 0;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    `CHK("init_busy", 1'b1, init_busy)
    h.wr(asc_pkg::ADDR_GAIN, 8'h5a);
    wait_lvl(0, 1'b0, INIT + 50);
    `CHK("init_end", 1'b0, init_busy)
    `CHK("gain_in_init", 1'b0, gain_out === 8'h5a)
    h.rd(asc_pkg::ADDR_RESET, rv);
    `CHK("reset_reg", asc_pkg::RESET_RST, rv)
    h.rd(asc_pkg::ADDR_MODE, rv);
    `CHK("mode_reg", asc_pkg::MODE_RST, rv)
    // Soft reset re-enters init and the reset bit stays at one.
    h.wr(asc_pkg::ADDR_RESET, asc_pkg::ZERO8);
    `CHK("soft_init", 1'b1, init_busy)
    wait_lvl(0, 1'b0, INIT + 50);
    `CHK("soft_end", 1'b0, init_busy)
    h.rd(asc_pkg::ADDR_RESET, rv);
    `CHK("reset_back", asc_pkg::RESET_RST, rv)
    // Standby runs the timer on the slow oscillator.
    // Standby enters its wait after the third settled conversion.
    h.wr(asc_pkg::ADDR_MODE, 8'h02);
    wait_lvl(1, 1'b1, STAB + 2 * SAMPLE_PERIOD * 3 + 2000);
    `CHK("slow_osc", 1'b1, slow_osc)
    wait_lvl(1, 1'b0, SBY + 100);
    `CHK("sb_expire", 1'b0, slow_osc)
    `CHK("sb_len", 1'b1, n > SBY - 100)
    h.rd(asc_pkg::ADDR_STATUS, rv);
    `CHK("sb_status", 8'h01, rv)
    // Stop, set a permitted clock mix, then start.
    h.wr(asc_pkg::ADDR_MODE, asc_pkg::MODE_RST);
    h.wr(asc_pkg::ADDR_CLOCKS, 8'h03);
    h.rd(asc_pkg::ADDR_CLOCKS, rv);
    `CHK("clocks", 8'h03, rv)
    h.wr(asc_pkg::ADDR_MODE, asc_pkg::ZERO8);
    t0 = cyc;
    repeat (STAB) @(posedge mclk);
    // Gain and channel rewrites are taken while running, a clocks rewrite is not.
    h.wr(asc_pkg::ADDR_GAIN, 8'h11);
    h.wr(asc_pkg::ADDR_ACHAN, 8'h22);
    h.wr(asc_pkg::ADDR_CLOCKS, asc_pkg::ZERO8);
    `CHK("gain_out", 8'h11, gain_out)
    `CHK("achan_out", 8'h22, achan_out)
    h.rd(asc_pkg::ADDR_CLOCKS, rv);
    `CHK("clocks_run", 8'h03, rv)
    h.rd(asc_pkg::ADDR_STATUS, rv);
    `CHK("status_stab", asc_pkg::ZERO8, rv)
    // First data ready after stabilisation plus one sample period.
    wait_lvl(2, 1'b1, STAB + SAMPLE_PERIOD + 2000);
    n = cyc - t0;
    `CHK("first_int", 1'b1, n > STAB + SAMPLE_PERIOD - 100)
    `CHK("int_period", 1'b1, n < STAB + SAMPLE_PERIOD + 600)
    // Status first, then data, all before the next sample.
    ev = asc_pkg::ZERO8;
    ev[asc_pkg::STAT_RDY_BIT] = 1'b1;
    ev[asc_pkg::STAT_GINV_BIT] = 1'b1;
    h.rd(asc_pkg::ADDR_STATUS, rv);
    `CHK("status", ev, rv)
    for (int k = 0; k < 4; k++) begin
      h.rd(8'(asc_pkg::ADDR_DATA_I_HI + k), rv);
      `CHK("data", 8'({conv_i, conv_v} >> (24 - 8 * k)), rv)
    end
    h.rd(asc_pkg::ADDR_STATUS, rv);
    `CHK("status_clr", asc_pkg::ZERO8, rv)
    wait_lvl(2, 1'b0, 40000);
    `CHK("int_end", 1'b0, int_pin)
    finish_test();
  end
endmodule
